// File: core/reg_attr_pkg.sv
// constants for the register bit attribute bank
package reg_attr_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    // register indices
    localparam logic [3:0] IDX_STATUS  = 4'h0;
    localparam logic [3:0] IDX_EVENTS  = 4'h1;
    localparam logic [3:0] IDX_CONTROL = 4'h2;
    localparam logic [3:0] IDX_COUNTER = 4'h3;
    localparam logic [3:0] IDX_SCRATCH = 4'h4;
    localparam logic [3:0] IDX_KEEP    = 4'h5;
    localparam logic [3:0] IDX_WRONLY  = 4'h6;
    // status register fields
    localparam int ST_RO_LO      = 0;
    localparam int ST_RO_W       = 8;
    localparam int ST_ROLAT_BIT  = 8;
    localparam int ST_LATLO_BIT  = 9;
    localparam int ST_LATHI_BIT  = 10;
    localparam int ST_SETRD_BIT  = 11;
    // event register fields
    localparam int EV_W          = 8;
    localparam int EV_STICKY_BIT = 8;
    // control register fields
    localparam int CT_GO_BIT     = 0;
    localparam int CT_EN_BIT     = 1;
    localparam int CT_MODE_LO    = 4;
    localparam int CT_MODE_W     = 4;
    // counter and scratch widths
    localparam int CNT_W         = 16;
    localparam int ANYCLR_LO     = 16;
    localparam int ANYCLR_W      = 16;
    localparam int SCRATCH_W     = 16;
    // reset values
    localparam logic [CT_MODE_W-1:0] MODE_RST = 4'h0;
    localparam logic [DATA_W-1:0]    SCRATCH_RST = 32'h0000_0000;
    localparam logic [DATA_W-1:0]    KEEP_RST    = 32'h0000_0000;
    localparam logic [DATA_W-1:0]    WRONLY_RST  = 32'h0000_0000;
    localparam logic [DATA_W-1:0]    UNMAPPED_RD = 32'h0000_0000;
endpackage : reg_attr_pkg

// File: core/reg_attr_bank.sv
// register bank with per-bit access attributes
`timescale 1ns/1ps
// one latch bit: its cause drives it off the idle level, a read brings it back
module read_clear_latch
    import reg_attr_pkg::*;
#(
    parameter logic IDLE = 1'b0
)
(
    input  wire logic sys_clk,
    input  wire logic any_rst,
    input  wire logic cause,
    input  wire logic rd_hit,
    output logic      state
);
    logic next_state;

    // cause wins over the read, so an event in the read cycle is not lost
    always_comb
    begin
        next_state = state;
        if (cause)
            next_state = ~IDLE;
        else if (rd_hit)
            next_state = IDLE;
    end

    always_ff @(posedge sys_clk)
    begin
        if (any_rst)
            state <= IDLE;
        else
            state <= next_state;
    end
endmodule : read_clear_latch

module reg_attr_bank
    import reg_attr_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              rstn,
    input  wire logic              soft_rst,
    input  wire logic              rd_en,
    input  wire logic              wr_en,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wr_data,
    output logic      [DATA_W-1:0] rd_data,
    input  wire logic [ST_RO_W-1:0] hw_status,
    input  wire logic              link_up,
    input  wire logic              err_cond,
    input  wire logic              fault_cond,
    input  wire logic [EV_W-1:0]   hw_events,
    input  wire logic              sticky_cond,
    input  wire logic              cnt_inc,
    input  wire logic              go_done,
    output logic                   go,
    output logic                   enable,
    output logic [CT_MODE_W-1:0]   mode,
    output logic [DATA_W-1:0]      keep_value,
    output logic [DATA_W-1:0]      wronly_value
);
    logic                 any_rst;
    logic                 rd_status;
    logic                 rd_counter;
    logic                 wr_events;
    logic                 wr_control;
    logic                 wr_counter;
    logic                 wr_scratch;
    logic                 wr_keep;
    logic                 wr_wronly;
    logic                 readonly_latch_high;
    logic                 readonly_latch_read;
    logic                 latch_low;
    logic                 latch_high;
    logic                 set_on_read;
    logic [EV_W-1:0]      write_one_clear;
    logic                 sticky;
    logic [CNT_W-1:0]     clear_on_read;
    logic [ANYCLR_W-1:0]  write_any_clear;
    logic [SCRATCH_W-1:0] scratch_lo;
    logic [DATA_W-1:0]    next_rd_data;
    logic                 next_readonly_latch_high;
    logic                 next_readonly_latch_read;
    logic                 next_set_on_read;
    logic [EV_W-1:0]      next_write_one_clear;
    logic                 next_sticky;
    logic [CNT_W-1:0]     next_clear_on_read;
    logic [ANYCLR_W-1:0]  next_write_any_clear;
    logic [SCRATCH_W-1:0] next_scratch_lo;
    logic                 next_go;
    logic                 next_enable;
    logic [CT_MODE_W-1:0] next_mode;
    logic [DATA_W-1:0]    next_keep;
    logic [DATA_W-1:0]    next_wronly;

    assign any_rst    = !rstn || soft_rst;
    assign rd_status  = rd_en && (addr == IDX_STATUS);
    assign rd_counter = rd_en && (addr == IDX_COUNTER);
    assign wr_events  = wr_en && (addr == IDX_EVENTS);
    assign wr_control = wr_en && (addr == IDX_CONTROL);
    assign wr_counter = wr_en && (addr == IDX_COUNTER);
    assign wr_scratch = wr_en && (addr == IDX_SCRATCH);
    assign wr_keep    = wr_en && (addr == IDX_KEEP);
    assign wr_wronly  = wr_en && (addr == IDX_WRONLY);

    // read mux, registered; reads show the value before this read's side effects
    always_comb
    begin
        next_rd_data = rd_data;
        if (rd_en)
        begin
            next_rd_data = UNMAPPED_RD;
            case (addr)
                IDX_STATUS:
                begin
                    next_rd_data[ST_RO_LO +: ST_RO_W] = hw_status;
                    next_rd_data[ST_ROLAT_BIT] = readonly_latch_high;
                    next_rd_data[ST_LATLO_BIT] = latch_low;
                    next_rd_data[ST_LATHI_BIT] = latch_high;
                    next_rd_data[ST_SETRD_BIT] = set_on_read;
                end
                IDX_EVENTS:
                begin
                    next_rd_data[EV_W-1:0]     = write_one_clear;
                    next_rd_data[EV_STICKY_BIT] = sticky;
                end
                IDX_CONTROL:
                begin
                    next_rd_data[CT_GO_BIT] = go;
                    next_rd_data[CT_EN_BIT] = enable;
                    next_rd_data[CT_MODE_LO +: CT_MODE_W] = mode;
                end
                IDX_COUNTER:
                begin
                    next_rd_data[CNT_W-1:0] = clear_on_read;
                    next_rd_data[ANYCLR_LO +: ANYCLR_W] = write_any_clear;
                end
                IDX_SCRATCH: next_rd_data[SCRATCH_W-1:0] = scratch_lo;
                IDX_KEEP:    next_rd_data = keep_value;
                IDX_WRONLY:  next_rd_data = UNMAPPED_RD;
                default:     next_rd_data = UNMAPPED_RD;
            endcase
        end
    end

    // read-only latch-high and set-on-read bits
    always_comb
    begin
        next_readonly_latch_high = readonly_latch_high;
        next_readonly_latch_read = readonly_latch_read;
        next_set_on_read         = set_on_read;
        // once read, the bit follows its cause down without another read
        if (link_up)
            next_readonly_latch_high = 1'b1;
        else if (rd_status || readonly_latch_read)
            next_readonly_latch_high = 1'b0;
        if (!next_readonly_latch_high)
            next_readonly_latch_read = 1'b0;
        else if (rd_status)
            next_readonly_latch_read = 1'b1;
        if (rd_status)
            next_set_on_read = 1'b1;
    end

    // latch bits held until the status register is read
    read_clear_latch #(.IDLE(1'b0)) latch_high_u
    (
        .sys_clk (sys_clk),
        .any_rst (any_rst),
        .cause   (err_cond),
        .rd_hit  (rd_status),
        .state   (latch_high)
    );
    read_clear_latch #(.IDLE(1'b1)) latch_low_u
    (
        .sys_clk (sys_clk),
        .any_rst (any_rst),
        .cause   (fault_cond),
        .rd_hit  (rd_status),
        .state   (latch_low)
    );

    // event bits and the level-sticky bit
    always_comb
    begin
        next_write_one_clear = (write_one_clear & ~(wr_events ? wr_data[EV_W-1:0] : '0))
                               | hw_events;
        next_sticky = sticky;
        if (sticky_cond)
            next_sticky = 1'b1;
        else if (wr_events && !wr_data[EV_STICKY_BIT])
            next_sticky = 1'b0;
    end

    // clear-on-read count, saturating write-any-clear count, scratch
    always_comb
    begin
        next_clear_on_read = clear_on_read;
        if (rd_counter)
            next_clear_on_read = '0;
        if (cnt_inc)
            next_clear_on_read = (rd_counter ? CNT_W'(0) : clear_on_read) + CNT_W'(1);
        next_write_any_clear = write_any_clear;
        if (wr_counter)
            next_write_any_clear = '0;
        if (cnt_inc && (write_any_clear != '1) && !wr_counter)
            next_write_any_clear = write_any_clear + ANYCLR_W'(1);
        next_scratch_lo = wr_scratch ? wr_data[SCRATCH_W-1:0] : scratch_lo;
    end

    // control bits
    always_comb
    begin
        next_go     = go;
        next_enable = enable;
        next_mode   = mode;
        next_keep   = wr_keep ? wr_data : keep_value;
        next_wronly = wr_wronly ? wr_data : wronly_value;
        if (go && go_done)
            next_go = 1'b0;
        if (wr_control)
        begin
            if (wr_data[CT_GO_BIT])
                next_go = 1'b1;
            next_enable = wr_data[CT_EN_BIT];
            next_mode   = wr_data[CT_MODE_LO +: CT_MODE_W];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
            rd_data <= UNMAPPED_RD;
        else
            rd_data <= next_rd_data;
    end

    // status group
    always_ff @(posedge sys_clk)
    begin
        if (any_rst)
        begin
            readonly_latch_high <= 1'b0;
            readonly_latch_read <= 1'b0;
            set_on_read         <= 1'b0;
        end
        else
        begin
            readonly_latch_high <= next_readonly_latch_high;
            readonly_latch_read <= next_readonly_latch_read;
            set_on_read         <= next_set_on_read;
        end
    end

    // event group
    always_ff @(posedge sys_clk)
    begin
        if (any_rst)
        begin
            write_one_clear <= '0;
            sticky          <= 1'b0;
        end
        else
        begin
            write_one_clear <= next_write_one_clear;
            sticky          <= next_sticky;
        end
    end

    // counter group
    always_ff @(posedge sys_clk)
    begin
        if (any_rst)
        begin
            clear_on_read   <= '0;
            write_any_clear <= '0;
            scratch_lo      <= SCRATCH_RST[SCRATCH_W-1:0];
        end
        else
        begin
            clear_on_read   <= next_clear_on_read;
            write_any_clear <= next_write_any_clear;
            scratch_lo      <= next_scratch_lo;
        end
    end

    // control group
    always_ff @(posedge sys_clk)
    begin
        if (any_rst)
        begin
            go           <= 1'b0;
            enable       <= 1'b0;
            mode         <= MODE_RST;
            wronly_value <= WRONLY_RST;
        end
        else
        begin
            go           <= next_go;
            enable       <= next_enable;
            mode         <= next_mode;
            wronly_value <= next_wronly;
        end
    end

    // exempt from software reset, only power-on reset
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
            keep_value <= KEEP_RST;
        else
            keep_value <= next_keep;
    end
endmodule : reg_attr_bank

// File: bench/reg_attr_bank_checker.sv
// assertions on the register attribute bank ports
`timescale 1ns/1ps
module reg_attr_bank_checker
    import reg_attr_pkg::*;
(
    input wire logic               sys_clk,
    input wire logic               rstn,
    input wire logic               soft_rst,
    input wire logic               rd_en,
    input wire logic               wr_en,
    input wire logic [ADDR_W-1:0]  addr,
    input wire logic [DATA_W-1:0]  wr_data,
    input wire logic [DATA_W-1:0]  rd_data,
    input wire logic [ST_RO_W-1:0] hw_status,
    input wire logic               go_done,
    input wire logic               go,
    input wire logic [DATA_W-1:0]  keep_value
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    sequence s_ctl_wr;
        wr_en && !soft_rst && addr == IDX_CONTROL;
    endsequence
    a_go_set: assert property (s_ctl_wr ##0 wr_data[CT_GO_BIT] |=> go)
        else $error("go not set by write");
    a_go_zero_kept: assert property (s_ctl_wr ##0 (go && !go_done && !wr_data[CT_GO_BIT])
        |=> go) else $error("zero write changed go");
    a_go_self_clear: assert property (go && go_done && !soft_rst
        && !(wr_en && addr == IDX_CONTROL) |=> !go) else $error("go did not clear");
    a_soft_go_clear: assert property (soft_rst && !wr_en |=> !go) else $error("go kept");
    a_keep_exempt: assert property (soft_rst && !wr_en |=> $stable(keep_value))
        else $error("keep value lost on soft reset");
    a_status_live: assert property (rd_en && addr == IDX_STATUS
        |=> rd_data[ST_RO_W-1:0] == $past(hw_status)) else $error("status not live");
    a_wronly_zero: assert property (rd_en && addr >= IDX_WRONLY |=> rd_data == UNMAPPED_RD)
        else $error("write-only read not zero");
    a_rd_holds: assert property (!rd_en |=> $stable(rd_data)) else $error("rd moved");
endmodule : reg_attr_bank_checker
bind reg_attr_bank reg_attr_bank_checker chk_u (.*);

// File: bench/reg_attr_bank_tb.sv
// self-checking bench for the register attribute bank
`timescale 1ns/1ps
module reg_attr_bank_tb;
    import reg_attr_pkg::*;
    logic                 sys_clk = 1'h0, rstn = 1'h0, soft_rst = 1'h0, rd_en = 1'h0, wr_en = 1'h0;
    logic                 link_up = 1'h0, err_cond = 1'h0, fault_cond = 1'h0, sticky_cond = 1'h0;
    logic                 cnt_inc = 1'h0, go_done = 1'h0, go, enable;
    logic [ADDR_W-1:0]    addr = 4'h0;
    logic [DATA_W-1:0]    wr_data = 32'h0, rd_data, keep_value, wronly_value;
    logic [ST_RO_W-1:0]   hw_status = 8'h5a;
    logic [EV_W-1:0]      hw_events = 8'h00;
    logic [CT_MODE_W-1:0] mode;
    int                   miscompares, checks_done, cycles;
    reg_attr_bank dut_u (.sys_clk, .rstn, .soft_rst, .rd_en, .wr_en, .addr, .wr_data, .rd_data,
        .hw_status, .link_up, .err_cond, .fault_cond, .hw_events, .sticky_cond, .cnt_inc,
        .go_done, .go, .enable, .mode, .keep_value, .wronly_value);
    initial forever #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
        if (++cycles == 3000)
            summarize();
    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // zero mask writes d, otherwise reads and compares under the mask
    task automatic acc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, m);
        @(posedge sys_clk) #1;
        {wr_en, rd_en, addr, wr_data} = {m == '0, m != '0, a, d};
        @(posedge sys_clk) #1;
        {wr_en, rd_en} = 2'h0;
        if (m != '0)
            chk(rd_data & m, d);
    endtask : acc
    task automatic summarize;
        miscompares += int'(cycles >= 3000);
        if (miscompares == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : summarize
    task automatic t_status;
        acc(IDX_STATUS, 32'h25a, 32'hfff);
        acc(IDX_STATUS, 32'hf00, '0);
        acc(IDX_STATUS, 32'ha5a, 32'hfff);
        {link_up, err_cond, fault_cond} = 3'h7;
        @(posedge sys_clk) #1;
        {err_cond, fault_cond} = 2'h0;
        acc(IDX_STATUS, 32'hd5a, 32'hfff);
        link_up = 1'h0;
        acc(IDX_STATUS, 32'ha5a, 32'hfff);
        link_up = 1'h1;
        @(posedge sys_clk) #1;
        link_up = 1'h0;
        acc(IDX_STATUS, 32'hb5a, 32'hfff);
        acc(IDX_STATUS, 32'ha5a, 32'hfff);
    endtask : t_status
    task automatic t_events;
        {hw_events, sticky_cond} = {8'hc3, 1'h1};
        @(posedge sys_clk) #1;
        hw_events = 8'h00;
        acc(IDX_EVENTS, 32'h1c3, 32'h1ff);
        acc(IDX_EVENTS, 32'h081, '0);
        acc(IDX_EVENTS, 32'h142, 32'h1ff);
        sticky_cond = 1'h0;
        acc(IDX_EVENTS, 32'h142, 32'h1ff);
        acc(IDX_EVENTS, 32'h000, '0);
        acc(IDX_EVENTS, 32'h042, 32'h1ff);
    endtask : t_events
    task automatic t_counter;
        cnt_inc = 1'h1;
        repeat (3) @(posedge sys_clk);
        #1 cnt_inc = 1'h0;
        acc(IDX_COUNTER, 32'h0, '0);
        acc(IDX_COUNTER, 32'h0000_0003, '1);
        acc(IDX_COUNTER, 32'h0000_0000, '1);
    endtask : t_counter
    task automatic t_soft;
        acc(IDX_CONTROL, 32'h0000_00a3, '0);
        acc(IDX_CONTROL, 32'h0000_00a2, '0);
        acc(IDX_CONTROL, 32'h0000_00a3, 32'hf3);
        go_done = 1'h1;
        @(posedge sys_clk) #1;
        go_done = 1'h0;
        chk({26'h0, go, enable, mode}, 32'h1a);
        acc(IDX_KEEP, 32'hdead_beef, '0);
        acc(IDX_WRONLY, 32'h1234_5678, '0);
        acc(IDX_WRONLY, 32'h0, '1);
        chk(wronly_value, 32'h1234_5678);
        acc(IDX_SCRATCH, 32'h0000_c0de, '0);
        acc(IDX_SCRATCH, 32'h0000_c0de, 32'hffff);
        soft_rst = 1'h1;
        @(posedge sys_clk) #1;
        soft_rst = 1'h0;
        chk(keep_value, 32'hdead_beef);
        chk(wronly_value, WRONLY_RST);
        acc(IDX_CONTROL, 32'h0, 32'hf3);
        acc(IDX_STATUS, 32'h200, 32'hf00);
        acc(IDX_SCRATCH, SCRATCH_RST & 32'h0000_ffff, 32'hffff);
        rstn = 1'h0;
        @(posedge sys_clk) #1;
        rstn = 1'h1;
        chk(keep_value, KEEP_RST);
    endtask : t_soft
    initial
    begin
        #16 rstn = 1'h1;
        t_status();
        t_events();
        t_counter();
        t_soft();
        summarize();
    end
endmodule : reg_attr_bank_tb
